// [rtl/iee_pkg.sv]
package iee_pkg;
   localparam logic [7:0] IEE_GPR_OFFSET = 8'h06;
   localparam logic [11:0] IEE_APB_GPR = 12'h018;
   localparam logic [11:0] IEE_APB_STAT = 12'h01C;
   localparam int IEE_SDA_BIT = 6;
   localparam int IEE_SCL_BIT = 7;
   localparam logic [7:0] IEE_GPR_RESET = 8'hC0;
   localparam int IEE_MEM_DEPTH = 16;
   localparam int IEE_MEM_AW = 4;
   localparam int IEE_FIFO_DEPTH = 16;
   localparam logic [6:0] IEE_DEV_CODE = 7'h50;
   localparam logic [3:0] IEE_WR_CYCLES = 4'h2;

   typedef enum logic [2:0] {
      IEE_IDLE = 3'b000,
      IEE_DEVB = 3'b001,
      IEE_ADDR = 3'b010,
      IEE_WDAT = 3'b011,
      IEE_RDAT = 3'b100,
      IEE_SKIP = 3'b101
   } iee_state_e;

   // Edge tests on the previous and current level of a line.
   function automatic logic iee_rise(input logic prev, input logic cur);
      iee_rise = !prev && cur;
   endfunction : iee_rise

   function automatic logic iee_fall(input logic prev, input logic cur);
      iee_fall = prev && !cur;
   endfunction : iee_fall
endpackage : iee_pkg

// [rtl/iee_mem_if.sv]
`timescale 1ns/1ns
// Write requests and read port of the data memory.
interface iee_mem_if;
   logic wr_valid;
   logic wr_ready;
   logic [11:0] wr_word;
   logic [3:0] rd_addr;
   logic [7:0] rd_data;
   modport ctl (output wr_valid, input wr_ready, output wr_word,
      output rd_addr, input rd_data);
   modport mem (input wr_valid, output wr_ready, input wr_word,
      input rd_addr, output rd_data);
endinterface : iee_mem_if

// [rtl/iee_fifo.sv]
`timescale 1ns/1ns
// Write buffer with valid and ready on both sides.
module iee_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW:0] wp;
      logic [AW:0] rp;
   } iee_fifo_s;
   iee_fifo_s s_r, s_nxt;
   logic [WIDTH-1:0] mem [DEPTH];
   logic full, empty, push, pop;

   // Status flags from pointer difference.
   assign empty = s_r.wp == s_r.rp;
   assign full = (s_r.wp[AW] != s_r.rp[AW]) &&
      (s_r.wp[AW-1:0] == s_r.rp[AW-1:0]);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem[s_r.rp[AW-1:0]];
   assign push = in_valid && !full;
   assign pop = out_ready && !empty;

   // Pointer updates.
   always_comb begin
      s_nxt = s_r;
      if (push) begin
         s_nxt.wp = s_r.wp + 1'b1;
      end
      if (pop) begin
         s_nxt.rp = s_r.rp + 1'b1;
      end
   end

   // Pointer register.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Storage array, no reset needed.
   always_ff @(posedge clk) begin
      if (push) begin
         mem[s_r.wp[AW-1:0]] <= in_data;
      end
   end
endmodule : iee_fifo

// [rtl/iee_mem.sv]
`timescale 1ns/1ns
// Sixteen byte store, buffered writes and registered read data.
module iee_mem
   import iee_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   iee_mem_if.mem mp
);
   typedef struct packed {
      logic [7:0] rd;
      logic [3:0] busy;
   } iee_mem_s;
   iee_mem_s s_r, s_nxt;
   logic [7:0] cells [IEE_MEM_DEPTH];
   logic q_valid, q_ready;
   logic [11:0] q_word;

   iee_fifo #(.WIDTH(12), .DEPTH(IEE_FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(mp.wr_valid),
      .in_ready(mp.wr_ready),
      .in_data(mp.wr_word),
      .out_valid(q_valid),
      .out_ready(q_ready),
      .out_data(q_word)
   );

   // A programming cycle stalls the drain for a few clocks.
   assign q_ready = s_r.busy == 4'h0;
   assign mp.rd_data = s_r.rd;

   // Read register and write pacing.
   always_comb begin
      s_nxt = s_r;
      s_nxt.rd = cells[mp.rd_addr];
      if (q_valid && q_ready) begin
         s_nxt.busy = IEE_WR_CYCLES;
      end else if (s_r.busy != 4'h0) begin
         s_nxt.busy = s_r.busy - 4'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (q_valid && q_ready) begin
         cells[q_word[11:8]] <= q_word[7:0];
      end
   end
endmodule : iee_mem

// [rtl/iee_top.sv]
`timescale 1ns/1ns
// Processor port register with internal two-wire bus to the data memory.
module iee_top
   import iee_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [5:0] EXT_PIN_IN,
   output logic [5:0] EXT_PIN_OUT
);
   typedef struct packed {
      logic [7:0] gpr;
      logic [5:0] p1, p2, p3;
      logic scl_q, sda_q;
      logic sda_drv;
      iee_state_e st;
      logic [3:0] bitc;
      logic [7:0] shf;
      logic rw;
      logic [3:0] addr;
      logic nack;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [5:0] pin_out;
      logic wv;
      logic [11:0] ww;
   } iee_top_s;
   iee_top_s s_r, s_nxt;
   iee_mem_if mif ();
   logic scl, sda, scl_hi, start_c, stop_c, rise_c, fall_c;

   iee_mem u_mem (
      .clk(SYS_CLK),
      .rst_n(RESET_N),
      .mp(mif.mem)
   );

   assign scl = s_r.gpr[IEE_SCL_BIT];
   // wired-and of processor and memory drive
   assign sda = s_r.gpr[IEE_SDA_BIT] && !s_r.sda_drv;
   assign scl_hi = s_r.scl_q && scl;
   assign start_c = scl_hi && iee_fall(s_r.sda_q, sda);
   assign stop_c = scl_hi && iee_rise(s_r.sda_q, sda);
   assign rise_c = iee_rise(s_r.scl_q, scl);
   assign fall_c = iee_fall(s_r.scl_q, scl);

   assign mif.rd_addr = s_r.addr;
   assign mif.wr_valid = s_r.wv;
   assign mif.wr_word = s_r.ww;
   assign PRDATA = s_r.prdata;
   assign PREADY = s_r.pready;
   assign PSLVERR = s_r.pslverr;
   assign EXT_PIN_OUT = s_r.pin_out;

   // Bus slave, pin sampling and memory protocol engine.
   always_comb begin
      s_nxt = s_r;
      s_nxt.pready = 1'b0;
      s_nxt.pslverr = 1'b0;
      s_nxt.wv = 1'b0;
      s_nxt.scl_q = scl;
      s_nxt.sda_q = sda;
      s_nxt.p1 = EXT_PIN_IN;
      s_nxt.p2 = s_r.p1;
      s_nxt.p3 = s_r.p2;
      if (s_r.p2 == s_r.p3) begin
         s_nxt.pin_out = s_r.p3;
      end
      // One wait cycle, answer in the second access cycle.
      if (PSEL && PENABLE && !s_r.pready) begin
         s_nxt.pready = 1'b1;
         s_nxt.prdata = 32'h0000_0000;
         unique case (PADDR)
            IEE_APB_GPR: begin
               // data bit 6 and clock bit 7
               s_nxt.prdata = {24'h00_0000, scl, sda, s_r.pin_out};
            end
            IEE_APB_STAT: begin
               s_nxt.prdata = {20'h0_0000, s_r.nack, s_r.bitc,
                  s_r.addr, s_r.st};
               if (PWRITE) begin
                  s_nxt.pslverr = 1'b1;
               end
            end
            default: s_nxt.pslverr = 1'b1;
         endcase
      end
      // port write at handshake
      // The write lands at the edge that samples ready high, no earlier.
      if (PSEL && PENABLE && PWRITE && s_r.pready &&
         PADDR == IEE_APB_GPR) begin
         s_nxt.gpr = PWDATA[7:0];
      end
      if (start_c) begin
         s_nxt.st = IEE_DEVB;
         // The clock fall after a start wraps this to zero, not a bit.
         s_nxt.bitc = 4'hF;
         s_nxt.sda_drv = 1'b0;
      end else if (stop_c) begin
         s_nxt.st = IEE_IDLE;
         s_nxt.sda_drv = 1'b0;
      end else if (s_r.st != IEE_IDLE && s_r.st != IEE_SKIP) begin
         // sample at rising clock, checked stable by start/stop
         if (rise_c && s_r.bitc < 4'h8) begin
            s_nxt.shf = {s_r.shf[6:0], sda};
         end
         if (rise_c && s_r.bitc == 4'h8) begin
            s_nxt.nack = sda;
         end
         // memory changes data only after clock falls
         if (fall_c) begin
            s_nxt.bitc = (s_r.bitc == 4'h8) ? 4'h0 : s_r.bitc + 4'h1;
            s_nxt.sda_drv = 1'b0;
            if (s_r.bitc == 4'h7 && s_r.st != IEE_RDAT) begin
               s_nxt.sda_drv = 1'b1;
               unique case (s_r.st)
                  IEE_DEVB: begin
                     s_nxt.rw = s_r.shf[0];
                     if (s_r.shf[7:1] != IEE_DEV_CODE) begin
                        s_nxt.st = IEE_SKIP;
                        s_nxt.sda_drv = 1'b0;
                     end
                  end
                  IEE_ADDR: begin
                     s_nxt.addr = s_r.shf[3:0];
                  end
                  IEE_WDAT: begin
                     s_nxt.wv = 1'b1;
                     s_nxt.ww = {s_r.addr, s_r.shf};
                     s_nxt.addr = s_r.addr + 4'h1;
                     if (!mif.wr_ready) begin
                        s_nxt.sda_drv = 1'b0;
                     end
                  end
                  default: s_nxt.st = s_r.st;
               endcase
            end
            if (s_r.bitc == 4'h8) begin
               unique case (s_r.st)
                  IEE_DEVB: s_nxt.st = s_r.rw ? IEE_RDAT : IEE_ADDR;
                  IEE_ADDR: s_nxt.st = IEE_WDAT;
                  IEE_RDAT: begin
                     if (s_r.nack) begin
                        s_nxt.st = IEE_SKIP;
                     end
                  end
                  default: s_nxt.st = s_r.st;
               endcase
               if ((s_r.st == IEE_DEVB && s_r.rw) ||
                  (s_r.st == IEE_RDAT && !s_r.nack)) begin
                  s_nxt.shf = mif.rd_data;
                  s_nxt.sda_drv = !mif.rd_data[7];
               end
            end else if (s_r.st == IEE_RDAT && s_r.bitc < 4'h7) begin
               // Each rising clock rotates the byte, so the next bit is on top.
               s_nxt.sda_drv = !s_r.shf[7];
            end else if (s_r.st == IEE_RDAT && s_r.bitc == 4'h7) begin
               // Step early so the registered read port holds the next byte.
               s_nxt.addr = s_r.addr + 4'h1;
            end
         end
      end
   end

   // reset leaves both lines high, bus idle
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         s_r <= '0;
         s_r.gpr <= IEE_GPR_RESET;
         s_r.scl_q <= 1'b1;
         s_r.sda_q <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule : iee_top

// [bench/iee_top_asserts.sv]
`timescale 1ns/1ns
// Register bus timing and pin isolation, watched at the top ports.
module iee_top_asserts
   import iee_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic [5:0] EXT_PIN_IN,
   input wire logic [5:0] EXT_PIN_OUT
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RESET_N);
   // First access cycle of a transfer, and a quiet spell on the pins.
   sequence s_access;
      PSEL && $rose(PENABLE);
   endsequence
   sequence s_quiet;
      $stable(EXT_PIN_IN) [*8];
   endsequence
   a_ready_one_wait:
   assert property (s_access |=> PREADY) else $error("ready late");
   a_ready_single:
   assert property (PREADY |=> !PREADY) else $error("ready too long");
   a_ready_cause:
   assert property (PREADY |-> PSEL && PENABLE && $past(PSEL && PENABLE))
      else $error("ready without access");
   a_err_with_ready:
   assert property (PSLVERR |-> PREADY) else $error("stray error flag");
   a_unmapped_err:
   assert property (PREADY && PADDR != IEE_APB_GPR && PADDR != IEE_APB_STAT
      |-> PSLVERR) else $error("unmapped not refused");
   a_status_ro:
   assert property (PREADY && PWRITE && PADDR == IEE_APB_STAT |-> PSLVERR)
      else $error("status write not refused");
   a_port_ok:
   assert property (PREADY && PADDR == IEE_APB_GPR |-> !PSLVERR)
      else $error("port register refused");
   a_rd_held:
   assert property (!PREADY |-> $stable(PRDATA)) else $error("data moved");
   a_pins_follow:
   assert property (s_quiet |-> EXT_PIN_OUT == EXT_PIN_IN)
      else $error("pin copy wrong");
endmodule : iee_top_asserts

bind iee_top iee_top_asserts u_chk (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
   .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
   .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .EXT_PIN_IN(EXT_PIN_IN), .EXT_PIN_OUT(EXT_PIN_OUT));

// [bench/iee_cpu_model.sv]
`timescale 1ns/1ns
// Processor side: bit-bangs the two-wire bus through the port register.
module iee_cpu_model
   import iee_pkg::*;
(
   input wire logic clk,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata
);
   typedef struct {logic [31:0] m; logic [31:0] e; logic er;} iee_exp_s;
   iee_exp_s exp_q[$];
   iee_exp_s x;
   int error_cnt = 0;
   int checks_done = 0;
   logic hung = 1'b0;
`define IEE_CHK(nm, ex, sn) begin checks_done++; if ((sn) !== (ex)) begin \
   error_cnt++; $display("CHECK FAILED %s exp %h got %h", nm, ex, sn); end end
   // The bus is quiet at time zero.
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
   end
   // Each answer is paired with the oldest noted expectation.
   always @(posedge clk) begin
      if (pready === 1'b1) begin
         if (exp_q.size() == 0) `IEE_CHK("spare answer", 1'b0, 1'b1)
         else begin
            x = exp_q.pop_front();
            `IEE_CHK("read data", x.e, prdata & x.m)
            `IEE_CHK("error flag", x.er, pslverr)
         end
      end
   end
   // One register transfer, held until ready is sampled.
   task automatic xfer(input logic w, input logic [11:0] a,
         input logic [31:0] d, input logic [31:0] m, input logic [31:0] e,
         input logic er);
      int n;
      exp_q.push_back('{m, e, er});
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk) penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         error_cnt++;
         hung = 1'b1;
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : xfer
   // Sets both lines, then lets the memory settle.
   task automatic line(input logic c, input logic s);
      xfer(1'b1, IEE_APB_GPR, {24'h000000, c, s, 6'h00}, 32'h0, 32'h0, 1'b0);
      repeat (2) @(posedge clk);
   endtask : line
   task automatic probe(input logic v);
      xfer(1'b0, IEE_APB_GPR, 32'h0, 32'h40, {25'h0, v, 6'h00}, 1'b0);
   endtask : probe
   // one bit per pulse, data moves while clock low.
   task automatic put_bit(input logic b);
      line(1'b0, b);
      line(1'b1, b);
      line(1'b0, b);
   endtask : put_bit
   // memory acknowledges each byte in the ninth pulse.
   task automatic send(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) put_bit(b[i]);
      line(1'b0, 1'b1);
      line(1'b1, 1'b1);
      probe(1'b0);
      line(1'b0, 1'b1);
   endtask : send
   // read bits sampled in the clock high phase.
   task automatic recv(input logic [7:0] e, input logic ack);
      for (int i = 7; i >= 0; i--) begin
         line(1'b0, 1'b1);
         line(1'b1, 1'b1);
         probe(e[i]);
      end
      put_bit(ack);
   endtask : recv
   // start with both lines high, also used as the repeated start in rd_pair.
   task automatic start();
      line(1'b1, 1'b1);
      xfer(1'b0, IEE_APB_GPR, 32'h0, 32'hC0, 32'hC0, 1'b0);
      line(1'b1, 1'b0);
      line(1'b0, 1'b0);
   endtask : start
   // every operation ends with a stop.
   task automatic stop();
      line(1'b0, 1'b0);
      line(1'b1, 1'b0);
      line(1'b1, 1'b1);
   endtask : stop
   task automatic wr_pair(input logic [3:0] a, input logic [7:0] d0,
         input logic [7:0] d1);
      start();
      send({IEE_DEV_CODE, 1'b0});
      send({4'h0, a});
      send(d0);
      send(d1);
      stop();
   endtask : wr_pair
   task automatic rd_pair(input logic [3:0] a, input logic [7:0] e0,
         input logic [7:0] e1);
      start();
      send({IEE_DEV_CODE, 1'b0});
      send({4'h0, a});
      start();
      send({IEE_DEV_CODE, 1'b1});
      recv(e0, 1'b0);
      recv(e1, 1'b1);
      stop();
   endtask : rd_pair
   // a stop in mid-byte ends the write with nothing stored.
   task automatic abort(input logic [3:0] a, input logic [7:0] d);
      start();
      send({IEE_DEV_CODE, 1'b0});
      send({4'h0, a});
      put_bit(d[7]);
      put_bit(d[6]);
      stop();
   endtask : abort
endmodule : iee_cpu_model

// [bench/internal_eeprom_two_wire_bus_tb_top.sv]
`timescale 1ns/1ns
// Moves bytes through the port register and reads them back.
module internal_eeprom_two_wire_bus_tb_top
   import iee_pkg::*;
;
   logic sys_clk;
   logic reset_n;
   logic [5:0] ext_in;
   logic psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [31:0] rnd = 32'h00014B4B;
   logic [7:0] mirror [16];
   logic [3:0] a;

   iee_top dut (.SYS_CLK(sys_clk), .RESET_N(reset_n), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .EXT_PIN_IN(ext_in), .EXT_PIN_OUT());
   iee_cpu_model cpu (.clk(sys_clk), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata));

   function automatic logic [31:0] iee_next(input logic [31:0] v);
      iee_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : iee_next

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", cpu.checks_done, cpu.error_cnt);
      if (cpu.error_cnt == 0 && cpu.checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_of_test

   // Clock at 20 MHz.
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   // Cuts a hang short.
   initial begin
      for (int n = 0; n < 90000 && cpu.hung !== 1'b1; n++) @(posedge sys_clk);
      if (cpu.hung !== 1'b1) cpu.error_cnt++;
      end_of_test();
   end
   // Main sequence.
   initial begin
      reset_n = 1'b0;
      ext_in = 6'h00;
      repeat (4) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk);
      cpu.xfer(1'b0, IEE_APB_GPR, 32'h0, 32'hC0, 32'hC0, 1'b0);
      cpu.xfer(1'b0, 12'h020, 32'h0, 32'h0, 32'h0, 1'b1);
      cpu.xfer(1'b1, IEE_APB_STAT, 32'h0, 32'h0, 32'h0, 1'b1);
      $display("test registers ended");
      for (int p = 0; p < 3; p++) begin
         a = (p == 0) ? 4'hF : rnd[3:0];
         rnd = iee_next(rnd);
         mirror[a] = rnd[7:0];
         mirror[a + 4'h1] = rnd[15:8];
         cpu.wr_pair(a, rnd[7:0], rnd[15:8]);
         rnd = iee_next(rnd);
         repeat (20) @(posedge sys_clk);
         cpu.rd_pair(a, mirror[a], mirror[a + 4'h1]);
         $display("test pair %0d ended", p);
      end
      cpu.abort(a, ~mirror[a]);
      cpu.rd_pair(a, mirror[a], mirror[a + 4'h1]);
      $display("test abort ended");
      ext_in <= rnd[5:0];
      repeat (10) @(posedge sys_clk);
      cpu.xfer(1'b0, IEE_APB_GPR, 32'h0, 32'h3F,
         {26'h0, ext_in}, 1'b0);
      $display("test pins ended");
      end_of_test();
   end
endmodule : internal_eeprom_two_wire_bus_tb_top
